// ---- hdl/eeprom_pe_ctrl.sv ----
`timescale 1ns/1ps
// Functional notes
// - each block protect bit set refuses program and erase inside its range
// - whole array erase guard set refuses bulk and row erase
// - guard write only lands while voltage and lock are both clear
// - byte select wins; else row select picks 32-byte row or bulk
// - byte and row selects ignored while programming
// - erase mode one erases, zero programs
// - latch control one captures next array write; zero means normal reads
// - selects, erase mode and latch control writable only with voltage off
// - those bits may be written together or one by one
// - voltage enable applies program or erase voltage; clearing removes it
// - voltage enable sets only if latch control was already set
// - setting latch and voltage together sets only latch control
// - guard, selects, mode and latch hold while voltage applied
// - array writes ignored while voltage applied; latches unchanged
// - captured address and data frozen for the whole operation
// - misaligned word write captures only its lower byte
// - protect lock set freezes block protect bits and guard
module eeprom_pe_ctrl #(
   parameter int unsigned ARRAY_BYTES = eeprom_pe_pkg::ARRAY_BYTES
) (
   // clock and reset
   input  wire logic                                sys_clk,
   input  wire logic                                rst_n,
   // register port
   input  wire logic [eeprom_pe_pkg::REG_ADDR_W-1:0] reg_addr,
   input  wire logic [eeprom_pe_pkg::REG_DATA_W-1:0] reg_wdata,
   input  wire logic                                reg_wr,
   input  wire logic                                reg_rd,
   output logic      [eeprom_pe_pkg::REG_DATA_W-1:0] reg_rdata,
   // array write port from the bus
   input  wire logic                                arr_wr,
   input  wire logic [eeprom_pe_pkg::ARR_ADDR_W-1:0] arr_addr,
   input  wire logic [eeprom_pe_pkg::ARR_DATA_W-1:0] arr_wdata,
   input  wire logic                                arr_wide,
   // array macro controls
   output logic                                     pe_voltage_on,
   output logic                                     pe_erase,
   output logic      [1:0]                          pe_scope,
   output logic      [eeprom_pe_pkg::ARR_ADDR_W-1:0] pe_addr,
   output logic      [eeprom_pe_pkg::ARR_DATA_W-1:0] pe_data,
   output logic      [1:0]                          pe_byte_en,
   output logic                                     pe_refused,
   output logic                                     array_read_mode
);

   // ---------------------------------------------------------------
   // elaboration check
   // ---------------------------------------------------------------
   if (ARRAY_BYTES != 1024) begin : g_bad_size
      $error("eeprom_pe_ctrl: block map serves a 1024-byte array only");
   end

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [4:0]                     block_protect_bits_reg;
   logic                           whole_array_erase_guard_reg;
   logic                           byte_select_reg;
   logic                           row_select_reg;
   logic                           erase_mode_reg;
   logic                           latch_control_reg;
   logic                           voltage_enable_reg;
   logic                           protect_lock_reg;
   logic                           loaded_reg;
   logic                           ignored_write_reg;
   eeprom_pe_pkg::op_state_t       op_state_reg;
   eeprom_pe_pkg::op_state_t       op_state_next;
   eeprom_pe_pkg::scope_t          scope;
   logic                           wr_pe;
   logic                           wr_bp;
   logic                           wr_lock;
   logic                           cfg_open;
   logic                           prot_open;
   logic                           capture;
   logic                           hit_protected;
   logic                           refused;
   logic [7:0]                     pe_ctl_value;
   logic [7:0]                     bp_value;
   logic [7:0]                     status_value;
   logic [7:0]                     reg_rdata_next;

   pe_latch_if lat ();

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   assign wr_pe   = reg_wr && (reg_addr == eeprom_pe_pkg::OFS_PROGRAM_ERASE);
   assign wr_bp   = reg_wr
                  && (reg_addr == eeprom_pe_pkg::OFS_BLOCK_PROTECTION);
   assign wr_lock = reg_wr && (reg_addr == eeprom_pe_pkg::OFS_LOCK_CONFIG);

   // configuration writes pass only with voltage off
   assign cfg_open  = !voltage_enable_reg;
   assign prot_open = !voltage_enable_reg && !protect_lock_reg;

   // ---------------------------------------------------------------
   // block protection
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         block_protect_bits_reg <= eeprom_pe_pkg::RST_BLOCK_PROTECT;
      end else if (wr_bp && prot_open) begin
         block_protect_bits_reg <= reg_wdata[4:0];
      end
   end

   // ---------------------------------------------------------------
   // protect lock: once set, held until reset
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         protect_lock_reg <= 1'b0;
      end else if (wr_lock && reg_wdata[eeprom_pe_pkg::BIT_LOCK]) begin
         protect_lock_reg <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // whole array erase guard
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         whole_array_erase_guard_reg <= eeprom_pe_pkg::RST_GUARD;
      end else if (wr_pe && prot_open) begin
         whole_array_erase_guard_reg <=
            reg_wdata[eeprom_pe_pkg::BIT_GUARD];
      end
   end

   // ---------------------------------------------------------------
   // erase selects and mode, each field written on every access with voltage off
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         byte_select_reg <= 1'b0;
         row_select_reg  <= 1'b0;
         erase_mode_reg  <= 1'b0;
      end else if (wr_pe && cfg_open) begin
         byte_select_reg <= reg_wdata[eeprom_pe_pkg::BIT_BYTESEL];
         row_select_reg  <= reg_wdata[eeprom_pe_pkg::BIT_ROWSEL];
         erase_mode_reg  <= reg_wdata[eeprom_pe_pkg::BIT_ERASE];
      end
   end

   // ---------------------------------------------------------------
   // latch control
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_control_reg <= 1'b0;
      end else if (wr_pe && cfg_open) begin
         latch_control_reg <= reg_wdata[eeprom_pe_pkg::BIT_LATCH];
      end
   end

   // ---------------------------------------------------------------
   // voltage enable; held until software clears it
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         voltage_enable_reg <= 1'b0;
      end else if (wr_pe) begin
         if (!reg_wdata[eeprom_pe_pkg::BIT_VOLTAGE]) begin
            voltage_enable_reg <= 1'b0;
         end else if (latch_control_reg) begin
            // old latch value only, so a joint set leaves voltage off
            voltage_enable_reg <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // array write capture
   // ---------------------------------------------------------------
   assign capture = arr_wr && latch_control_reg
                  && !voltage_enable_reg;

   assign lat.capture = capture;
   assign lat.wr_addr = arr_addr;
   assign lat.wr_data = arr_wdata;
   assign lat.wide    = arr_wide;

   eeprom_op_latch u_latch (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .lp      (lat)
   );

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         loaded_reg <= 1'b0;
      end else if (!latch_control_reg) begin
         loaded_reg <= 1'b0;
      end else if (capture) begin
         loaded_reg <= 1'b1;
      end
   end

   // sticky until the next capture: a write lost to a live operation
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ignored_write_reg <= 1'b0;
      end else if (arr_wr && voltage_enable_reg) begin
         ignored_write_reg <= 1'b1;
      end else if (capture) begin
         ignored_write_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // erase scope and protection check
   // ---------------------------------------------------------------
   always_comb begin
      if (!erase_mode_reg)
         scope = eeprom_pe_pkg::SCOPE_BYTE;
      else if (byte_select_reg)
         scope = eeprom_pe_pkg::SCOPE_BYTE;
      else if (row_select_reg)
         scope = eeprom_pe_pkg::SCOPE_ROW;
      else
         scope = eeprom_pe_pkg::SCOPE_BULK;
   end

   assign hit_protected = |(lat.lat_block & block_protect_bits_reg);

   always_comb begin
      case (scope)
         eeprom_pe_pkg::SCOPE_BULK:
            refused = whole_array_erase_guard_reg
                    || (|block_protect_bits_reg);
         eeprom_pe_pkg::SCOPE_ROW:
            refused = whole_array_erase_guard_reg || hit_protected;
         eeprom_pe_pkg::SCOPE_BYTE:
            refused = hit_protected;
         default:
            refused = 1'b1;
      endcase
   end

   // ---------------------------------------------------------------
   // operation state
   // ---------------------------------------------------------------
   always_comb begin
      case (op_state_reg)
         eeprom_pe_pkg::OP_IDLE:
            op_state_next = latch_control_reg ? eeprom_pe_pkg::OP_ARMED
                                              : eeprom_pe_pkg::OP_IDLE;
         eeprom_pe_pkg::OP_ARMED:
            if (!latch_control_reg)
               op_state_next = eeprom_pe_pkg::OP_IDLE;
            else if (loaded_reg)
               op_state_next = eeprom_pe_pkg::OP_LOADED;
            else
               op_state_next = eeprom_pe_pkg::OP_ARMED;
         eeprom_pe_pkg::OP_LOADED:
            if (!latch_control_reg)
               op_state_next = eeprom_pe_pkg::OP_IDLE;
            else if (voltage_enable_reg)
               op_state_next = eeprom_pe_pkg::OP_ACTIVE;
            else
               op_state_next = eeprom_pe_pkg::OP_LOADED;
         eeprom_pe_pkg::OP_ACTIVE:
            op_state_next = voltage_enable_reg ? eeprom_pe_pkg::OP_ACTIVE
                                               : eeprom_pe_pkg::OP_LOADED;
         default:
            op_state_next = eeprom_pe_pkg::OP_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_state_reg <= eeprom_pe_pkg::OP_IDLE;
      end else begin
         op_state_reg <= op_state_next;
      end
   end

   // ---------------------------------------------------------------
   // array macro drive
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pe_voltage_on   <= 1'b0;
         pe_refused      <= 1'b0;
         array_read_mode <= 1'b1;
      end else begin
         pe_voltage_on   <= voltage_enable_reg && loaded_reg
                            && !refused;
         pe_refused      <= voltage_enable_reg && loaded_reg && refused;
         array_read_mode <= !latch_control_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pe_erase   <= 1'b0;
         pe_scope   <= eeprom_pe_pkg::SCOPE_BYTE;
         pe_addr    <= '0;
         pe_data    <= '0;
         pe_byte_en <= 2'h0;
      end else begin
         pe_erase   <= erase_mode_reg;
         pe_scope   <= scope;
         pe_addr    <= lat.lat_addr;
         pe_data    <= lat.lat_data;
         pe_byte_en <= lat.lat_be;
      end
   end

   // ---------------------------------------------------------------
   // read back
   // ---------------------------------------------------------------
   always_comb begin
      pe_ctl_value = 8'h00;
      pe_ctl_value[eeprom_pe_pkg::BIT_GUARD]   = whole_array_erase_guard_reg;
      pe_ctl_value[eeprom_pe_pkg::BIT_BYTESEL] = byte_select_reg;
      pe_ctl_value[eeprom_pe_pkg::BIT_ROWSEL]  = row_select_reg;
      pe_ctl_value[eeprom_pe_pkg::BIT_ERASE]   = erase_mode_reg;
      pe_ctl_value[eeprom_pe_pkg::BIT_LATCH]   = latch_control_reg;
      pe_ctl_value[eeprom_pe_pkg::BIT_VOLTAGE] = voltage_enable_reg;
   end

   assign bp_value     = {eeprom_pe_pkg::BLK_PROT_HIGH_RD,
                          block_protect_bits_reg};
   assign status_value = {3'h0, ignored_write_reg, refused, loaded_reg,
                          op_state_reg};

   always_comb begin
      case (reg_addr)
         eeprom_pe_pkg::OFS_BLOCK_PROTECTION: reg_rdata_next = bp_value;
         eeprom_pe_pkg::OFS_PROGRAM_ERASE:    reg_rdata_next = pe_ctl_value;
         eeprom_pe_pkg::OFS_LOCK_CONFIG:
            reg_rdata_next = {7'h00, protect_lock_reg};
         eeprom_pe_pkg::OFS_OP_STATUS:        reg_rdata_next = status_value;
         default:                             reg_rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= reg_rdata_next;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule // eeprom_pe_ctrl

// ---- pkg/eeprom_pe_pkg.sv ----
package eeprom_pe_pkg;

   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int unsigned ARRAY_BYTES = 1024;
   localparam int unsigned ARR_ADDR_W  = 10;
   localparam int unsigned ARR_DATA_W  = 16;
   localparam int unsigned REG_ADDR_W  = 8;
   localparam int unsigned REG_DATA_W  = 8;
   localparam int unsigned BLOCKS      = 5;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_BLOCK_PROTECTION = 8'hF1;
   localparam logic [7:0] OFS_PROGRAM_ERASE    = 8'hF3;
   localparam logic [7:0] OFS_LOCK_CONFIG      = 8'hF4;
   localparam logic [7:0] OFS_OP_STATUS        = 8'hF5;

   // ---------------------------------------------------------------
   // program_erase_control fields and the lock config bit
   // ---------------------------------------------------------------
   localparam int unsigned BIT_GUARD   = 7;
   localparam int unsigned BIT_BYTESEL = 4;
   localparam int unsigned BIT_ROWSEL  = 3;
   localparam int unsigned BIT_ERASE   = 2;
   localparam int unsigned BIT_LATCH   = 1;
   localparam int unsigned BIT_VOLTAGE = 0;
   localparam int unsigned BIT_LOCK    = 0;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [4:0] RST_BLOCK_PROTECT = 5'h1F;
   localparam logic       RST_GUARD         = 1'b1;
   localparam logic [2:0] BLK_PROT_HIGH_RD  = 3'h7;

   // ---------------------------------------------------------------
   // block boundaries (array byte offsets)
   // ---------------------------------------------------------------
   localparam logic [9:0] BLK3_BASE = 10'h200;
   localparam logic [9:0] BLK2_BASE = 10'h300;
   localparam logic [9:0] BLK1_BASE = 10'h380;
   localparam logic [9:0] BLK0_BASE = 10'h3C0;

   typedef enum logic [1:0] {
      SCOPE_BULK = 2'b00,
      SCOPE_ROW  = 2'b01,
      SCOPE_BYTE = 2'b10
   } scope_t;

   typedef enum logic [1:0] {
      OP_IDLE   = 2'b00,
      OP_ARMED  = 2'b01,
      OP_LOADED = 2'b10,
      OP_ACTIVE = 2'b11
   } op_state_t;

   // one-hot protection block of an array byte offset
   function automatic logic [4:0] block_hit(input logic [9:0] a);
      if (a < BLK3_BASE)
         block_hit = 5'h10;
      else if (a < BLK2_BASE)
         block_hit = 5'h08;
      else if (a < BLK1_BASE)
         block_hit = 5'h04;
      else if (a < BLK0_BASE)
         block_hit = 5'h02;
      else
         block_hit = 5'h01;
   endfunction

endpackage

// ---- pkg/pe_latch_if.sv ----
`timescale 1ns/1ps
interface pe_latch_if;
   logic        capture;
   logic [9:0]  wr_addr;
   logic [15:0] wr_data;
   logic        wide;
   logic [9:0]  lat_addr;
   logic [15:0] lat_data;
   logic [1:0]  lat_be;
   logic [4:0]  lat_block;

   modport ctrl (
      output capture, wr_addr, wr_data, wide,
      input  lat_addr, lat_data, lat_be, lat_block
   );
   modport latch (
      input  capture, wr_addr, wr_data, wide,
      output lat_addr, lat_data, lat_be, lat_block
   );
endinterface

// ---- hdl/eeprom_op_latch.sv ----
`timescale 1ns/1ps
module eeprom_op_latch (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // controller side
   pe_latch_if.latch lp
);

   // ---------------------------------------------------------------
   // address and data capture, held between captures
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lp.lat_addr  <= 10'h000;
         lp.lat_data  <= 16'h0000;
         lp.lat_be    <= 2'h0;
         lp.lat_block <= 5'h00;
      end else if (lp.capture) begin
         lp.lat_addr  <= lp.wr_addr;
         lp.lat_block <= eeprom_pe_pkg::block_hit(lp.wr_addr);
         if (lp.wide && !lp.wr_addr[0]) begin
            lp.lat_data <= lp.wr_data;
            lp.lat_be   <= 2'h3;
         end else begin
            // misaligned word keeps only its lower byte
            lp.lat_data <= {lp.wr_data[7:0], lp.wr_data[7:0]};
            lp.lat_be   <= lp.wr_addr[0] ? 2'h2 : 2'h1;
         end
      end
   end

endmodule // eeprom_op_latch

// ---- bench/eeprom_pe_ctrl_sva.sv ----
`timescale 1ns/1ps
module eeprom_pe_ctrl_sva #(
   parameter int unsigned ARRAY_BYTES = eeprom_pe_pkg::ARRAY_BYTES
) (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst_n,
   // register port
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   // array port
   input wire logic        arr_wr,
   input wire logic [9:0]  arr_addr,
   input wire logic [15:0] arr_wdata,
   input wire logic        arr_wide,
   // array macro controls
   input wire logic        pe_voltage_on,
   input wire logic        pe_erase,
   input wire logic [1:0]  pe_scope,
   input wire logic [9:0]  pe_addr,
   input wire logic [15:0] pe_data,
   input wire logic [1:0]  pe_byte_en,
   input wire logic        pe_refused,
   input wire logic        array_read_mode
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic pec_wr;
   logic held;
   logic lat_m;
   logic volt_m;
   assign pec_wr = reg_wr && reg_addr == eeprom_pe_pkg::OFS_PROGRAM_ERASE;

   chk_volt_latched: assert property (pe_voltage_on
      |-> !array_read_mode) else $error("voltage on without latch control");
   chk_volt_clear: assert property (pec_wr && !reg_wdata[0] |->
      ##[1:3] !pe_voltage_on) else $error("voltage not removed");
   chk_pair_latch: assert property (pec_wr && reg_wdata[1:0] == 2'h3
      && !lat_m |=> !pe_voltage_on [*2])
      else $error("voltage set together with latch");
   chk_addr_frozen: assert property (held |-> $stable(pe_addr)
      && $stable(pe_data) && $stable(pe_byte_en))
      else $error("latched target moved under voltage");
   chk_mode_frozen: assert property (held |-> $stable(pe_erase)
      && $stable(pe_scope)) else $error("mode moved under voltage");
   chk_prog_scope: assert property (!pe_erase |-> pe_scope == 2'h2)
      else $error("scope not byte while programming");
   chk_scope_legal: assert property (pe_scope != 2'h3)
      else $error("illegal erase scope");
   chk_refuse_off: assert property (pe_refused |-> !pe_voltage_on)
      else $error("voltage on a refused target");
   chk_hold_on: assert property ((pe_voltage_on && !reg_wr) [*4]
      |=> pe_voltage_on) else $error("voltage dropped by itself");
   chk_read_mode: assert property (pec_wr && !reg_wdata[1]
      && !volt_m |-> ##[1:2] array_read_mode)
      else $error("read mode not restored");

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         held <= 1'b0;
      else
         held <= pe_voltage_on;
   end

   // software view of latch and voltage bits
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lat_m  <= 1'b0;
         volt_m <= 1'b0;
      end else if (pec_wr) begin
         volt_m <= reg_wdata[0] && lat_m;
         if (!volt_m)
            lat_m <= reg_wdata[1];
      end
   end
   assign_held_note: cover property (held && pe_voltage_on);
   cov_bulk: cover property (pe_voltage_on && pe_erase && pe_scope == 2'h0);
   cov_refused: cover property (pe_refused);
   cov_odd_lane: cover property (pe_voltage_on && pe_byte_en == 2'h2);
endmodule // eeprom_pe_ctrl_sva

bind eeprom_pe_ctrl eeprom_pe_ctrl_sva #(.ARRAY_BYTES(ARRAY_BYTES)) u_sva (
   .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .arr_wr(arr_wr), .arr_addr(arr_addr),
   .arr_wdata(arr_wdata), .arr_wide(arr_wide),
   .pe_voltage_on(pe_voltage_on), .pe_erase(pe_erase),
   .pe_scope(pe_scope), .pe_addr(pe_addr), .pe_data(pe_data),
   .pe_byte_en(pe_byte_en), .pe_refused(pe_refused),
   .array_read_mode(array_read_mode));

// ---- bench/test_eeprom_pe_ctrl.sv ----
`timescale 1ns/1ps
module test_eeprom_pe_ctrl;
   localparam logic [7:0] PEC = eeprom_pe_pkg::OFS_PROGRAM_ERASE;
   localparam logic [7:0] BPR = eeprom_pe_pkg::OFS_BLOCK_PROTECTION;
   logic        sys_clk, rst_n, reg_wr, reg_rd, arr_wr, arr_wide;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rdv;
   logic [9:0]  arr_addr, pe_addr;
   logic [15:0] arr_wdata, pe_data;
   logic [1:0]  pe_scope, pe_byte_en;
   logic        pe_voltage_on, pe_erase, pe_refused, array_read_mode;
   logic [9:0]  tgt [5] = '{10'h010, 10'h210, 10'h310, 10'h390, 10'h3D0};
   logic [7:0]  ctl [4] = '{8'h06, 8'h0E, 8'h16, 8'h1E};
   logic [1:0]  scp [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
   int          n_mismatch = 0;
   int          n_checks = 0;

   eeprom_pe_ctrl DUT (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .arr_wr(arr_wr), .arr_addr(arr_addr),
      .arr_wdata(arr_wdata), .arr_wide(arr_wide),
      .pe_voltage_on(pe_voltage_on), .pe_erase(pe_erase),
      .pe_scope(pe_scope), .pe_addr(pe_addr), .pe_data(pe_data),
      .pe_byte_en(pe_byte_en), .pe_refused(pe_refused),
      .array_read_mode(array_read_mode));

   task automatic test_done();
      if (n_mismatch == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic aw(input logic [9:0] a, input logic [15:0] d,
                     input logic w);
      @(posedge sys_clk);
      arr_wr    <= 1'b1;
      arr_addr  <= a;
      arr_wdata <= d;
      arr_wide  <= w;
      @(posedge sys_clk);
      arr_wr <= 1'b0;
   endtask

   // latch, load target, request voltage, wait for outcome
   task automatic go(input logic [7:0] c, input logic [9:0] a,
                     input logic [15:0] d, input logic w);
      int i;
      wr(PEC, c);
      aw(a, d, w);
      wr(PEC, c | 8'h01);
      #1;
      for (i = 0; i < 8 && !pe_voltage_on && !pe_refused; i++) begin
         @(posedge sys_clk);
         #1;
      end
      if (i == 8) begin
         n_mismatch++;
         test_done();
      end
   endtask

   task automatic stop(input logic [7:0] c);
      wr(PEC, c & 8'hFE);
      wr(PEC, c & 8'hFC);
   endtask

   task automatic t_reset();
      rd(BPR, rdv);
      cmp("block_protection", 8'hFF, rdv);
      rd(PEC, rdv);
      cmp("program_erase_control", 8'h80, rdv);
      rd(8'h00, rdv);
      cmp("unmapped", 8'h00, rdv);
   endtask

   task automatic t_latch();
      wr(PEC, 8'h03);
      rd(PEC, rdv);
      cmp("latch_only", 8'h02, rdv);
      cmp("voltage", 1'b0, pe_voltage_on);
      cmp("read_mode", 1'b0, array_read_mode);
      wr(PEC, 8'h04);
      wr(PEC, 8'h06);
      rd(PEC, rdv);
      cmp("split_write", 8'h06, rdv);
      wr(PEC, 8'h00);
      rd(PEC, rdv);
      cmp("read_mode", 1'b1, array_read_mode);
   endtask

   task automatic t_blocks();
      for (int i = 0; i < 5; i++) begin
         wr(BPR, 8'h01 << (4 - i));
         go(8'h02, tgt[i], 16'h00A5, 1'b0);
         cmp("refused", 1'b1, pe_refused);
         stop(8'h02);
      end
      wr(BPR, 8'h00);
      go(8'h0A, 10'h3D0, 16'h00A5, 1'b0);
      cmp("voltage", 1'b1, pe_voltage_on);
      cmp("erase", 1'b0, pe_erase);
      cmp("scope", 2'h2, pe_scope);
      cmp("addr", 10'h3D0, pe_addr);
      cmp("data", 16'hA5A5, pe_data);
      cmp("lanes", 2'h1, pe_byte_en);
      aw(10'h100, 16'h005A, 1'b0);
      wr(PEC, 8'h9F);
      rd(PEC, rdv);
      cmp("held_bits", 8'h0B, rdv);
      rd(eeprom_pe_pkg::OFS_OP_STATUS, rdv);
      cmp("op_status", 8'h17, rdv);
      cmp("addr", 10'h3D0, pe_addr);
      cmp("data", 16'hA5A5, pe_data);
      repeat (50) @(posedge sys_clk);
      cmp("voltage", 1'b1, pe_voltage_on);
      stop(8'h0A);
   endtask

   task automatic t_erase();
      for (int i = 0; i < 4; i++) begin
         go(ctl[i], 10'h040, 16'h00FF, 1'b0);
         cmp("voltage", 1'b1, pe_voltage_on);
         cmp("erase", 1'b1, pe_erase);
         cmp("scope", scp[i], pe_scope);
         stop(ctl[i]);
      end
      go(8'h86, 10'h040, 16'h00FF, 1'b0);
      cmp("bulk_refused", 1'b1, pe_refused);
      stop(8'h86);
      go(8'h8E, 10'h040, 16'h00FF, 1'b0);
      cmp("row_refused", 1'b1, pe_refused);
      stop(8'h8E);
   endtask

   task automatic t_word();
      go(8'h02, 10'h021, 16'h1234, 1'b1);
      cmp("lanes", 2'h2, pe_byte_en);
      cmp("data", 16'h3434, pe_data);
      wr(PEC, 8'h02);
      go(8'h02, 10'h020, 16'h1234, 1'b1);
      cmp("lanes", 2'h3, pe_byte_en);
      cmp("data", 16'h1234, pe_data);
      stop(8'h02);
   endtask

   task automatic t_lock();
      wr(BPR, 8'h05);
      wr(eeprom_pe_pkg::OFS_LOCK_CONFIG, 8'h01);
      wr(BPR, 8'h1A);
      rd(BPR, rdv);
      cmp("block_protection", 8'hE5, rdv);
      rd(eeprom_pe_pkg::OFS_LOCK_CONFIG, rdv);
      cmp("protect_lock", 8'h01, rdv);
      wr(PEC, 8'h80);
      rd(PEC, rdv);
      cmp("guard_locked", 8'h00, rdv);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   initial begin
      rst_n     = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      arr_wr    = 1'b0;
      arr_addr  = 10'h000;
      arr_wdata = 16'h0000;
      arr_wide  = 1'b0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_latch();
      t_blocks();
      t_erase();
      t_word();
      t_lock();
      test_done();
   end
endmodule // test_eeprom_pe_ctrl
